// File: logic/awst_pkg.sv
// package for the area wait and sdram timing block: register map,
// field positions, reset values, request types and decode functions.
// assumes a 32-bit apb register bus and one 250 MHz bus clock.
package awst_pkg;

   // register byte offsets on the apb bus
   localparam logic [7:0] WAIT_CTRL_OFFSET = 8'h00;
   localparam logic [7:0] SDRAM_CTRL_OFFSET = 8'h04;
   localparam logic [7:0] STATUS_OFFSET = 8'h08;

   // reset values
   localparam logic [15:0] WAIT_CTRL_RESET = 16'hFFFF;
   localparam logic [15:0] SDRAM_CTRL_RESET = 16'h0000;

   // field positions in area_wait_control_two
   localparam int AREA4_WAIT_LSB = 7;
   localparam int AREA0_WAIT_LSB = 0;
   // field positions in sdram_timing_control
   localparam int PRECHARGE_LSB = 14;
   localparam int ROW_COL_LSB = 12;

   // timer counter width; largest count is 11 cycles
   localparam int CNT_W = 4;

   typedef enum logic [1:0] {
      MEM_AREA4,
      MEM_AREA0_FIRST,
      MEM_AREA0_BURST
   } awst_mem_kind_type;

   typedef enum logic [1:0] {
      GAP_ROW_TO_COL,
      GAP_PRE_NORMAL,
      GAP_PRE_AFTER_PRECHARGE,
      GAP_PRE_AFTER_SELF_REFRESH
   } awst_gap_kind_type;

   typedef struct packed {
      logic valid;
      awst_mem_kind_type kind;
   } awst_mem_req_type;

   typedef struct packed {
      logic valid;
      awst_gap_kind_type kind;
   } awst_gap_req_type;

   // inserted wait states for a first cycle, codes 000..111
   function automatic logic [CNT_W-1:0] wait_states(input logic [2:0] code);
      case (code)
         3'h0: wait_states = 4'h0;
         3'h1: wait_states = 4'h1;
         3'h2: wait_states = 4'h2;
         3'h3: wait_states = 4'h3;
         3'h4: wait_states = 4'h4;
         3'h5: wait_states = 4'h6;
         3'h6: wait_states = 4'h8;
         default: wait_states = 4'hA;
      endcase
   endfunction : wait_states

   // states per burst transfer after the first, codes 000..111
   function automatic logic [CNT_W-1:0] burst_states(input logic [2:0] code);
      case (code)
         3'h0: burst_states = 4'h2;
         3'h1: burst_states = 4'h2;
         3'h2: burst_states = 4'h3;
         3'h3: burst_states = 4'h4;
         3'h4: burst_states = 4'h4;
         3'h5: burst_states = 4'h6;
         3'h6: burst_states = 4'h8;
         default: burst_states = 4'hA;
      endcase
   endfunction : burst_states

endpackage : awst_pkg

// File: logic/awst_cycle_timer.sv
// down-counter that times one access or one sdram gap in bus cycles.
// assumes waitIn is already synchronised to clk.
module awst_cycle_timer #(
   parameter int CNT_W = 4
) (
   input wire logic clk, // bus clock
   input wire logic srst, // power-on reset
   input wire logic clear, // manual reset, aborts a running count
   input wire logic start, // one-cycle start, ignored while busy
   input wire logic [CNT_W-1:0] load, // cycles to count
   input wire logic honourWait, // stretch on waitIn at the end
   input wire logic waitIn, // synchronised external wait
   output logic busy, // count in progress
   output logic done // one-cycle pulse at the end
);

   typedef struct packed {
      logic busy;
      logic done;
      logic honour;
      logic [CNT_W-1:0] count;
   } awst_timer_state_type;

   awst_timer_state_type state;
   awst_timer_state_type next_state;

   // count down to one, then hold while wait is honoured and asserted
   always_comb begin
      next_state = state;
      next_state.done = 1'b0;
      if (clear) begin
         next_state.busy = 1'b0;
      end else if (!state.busy) begin
         if (start) begin
            next_state.busy = 1'b1;
            next_state.count = load;
            next_state.honour = honourWait;
         end
      end else if (state.count > {{(CNT_W-1){1'b0}}, 1'b1}) begin
         next_state.count = state.count - {{(CNT_W-1){1'b0}}, 1'b1};
      end else if (!(state.honour && waitIn)) begin
         next_state.busy = 1'b0;
         next_state.done = 1'b1;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign busy = state.busy;
   assign done = state.done;

endmodule : awst_cycle_timer

// File: logic/awst_timing_ctrl.sv
// wait-state and sdram gap timing for the bus state controller, with
// its two control registers and a status register on apb.
// assumes apb master and request sources on clk; waitPin is asynchronous.
//
// Operation
// - area 4 codes 000..111 insert 0,1,2,3,4,6,8,10 waits; wait pin off at 000
// - area 0 first cycle same wait table; wait pin ignored only at 000
// - 16-bit read/write sdram timing control register for areas 2 and 3
// - power-on reset clears sdram timing control to zero
// - manual reset and standby leave sdram timing control unchanged
// - precharge field gives 1 to 4 cycles before next bank-active, 1 to 3 after precharge, 2 to 11 after self-refresh
// - row-to-column field gives 1 to 4 cycles before read or write
module awst_timing_ctrl (
   input wire logic clk, // 250 MHz bus clock
   input wire logic srst, // power-on reset, synchronous, high
   input wire logic manualReset, // manual reset, same clock domain
   input wire logic standby, // standby mode, blocks new requests
   // apb slave
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [3:0] pstrb, // apb byte strobes
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   // ordinary memory access timing
   input wire awst_pkg::awst_mem_req_type memReq, // access start request
   input wire logic waitPin, // external wait, asynchronous
   output logic memBusy, // access being timed
   output logic memDone, // one-cycle pulse, access may end
   // sdram gap timing
   input wire awst_pkg::awst_gap_req_type gapReq, // gap start request
   output logic gapBusy, // gap being timed
   output logic gapDone, // one-cycle pulse, next command allowed
   // register contents for the rest of the controller
   output logic [15:0] waitCtrl, // area_wait_control_two
   output logic [15:0] sdramCtrl // sdram_timing_control
);

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [15:0] waitCtrl;
      logic [15:0] sdramCtrl;
      logic waitMeta;
      logic waitSync;
   } awst_main_state_type;

   awst_main_state_type state;
   awst_main_state_type next_state;

   logic setupPhase;
   logic accessDone;
   logic mapped;
   logic [31:0] readValue;
   logic [2:0] area4Code;
   logic [2:0] area0Code;
   logic [1:0] prechargeCode;
   logic [1:0] rowColCode;
   logic memStart;
   logic [awst_pkg::CNT_W-1:0] memLoad;
   logic memHonour;
   logic gapStart;
   logic [awst_pkg::CNT_W-1:0] gapLoad;

   // apb phases; the answer comes in the first access cycle
   assign setupPhase = psel && !penable;
   assign accessDone = psel && penable && state.pready;
   assign area4Code = state.waitCtrl[awst_pkg::AREA4_WAIT_LSB +: 3];
   assign area0Code = state.waitCtrl[awst_pkg::AREA0_WAIT_LSB +: 3];
   assign prechargeCode = state.sdramCtrl[awst_pkg::PRECHARGE_LSB +: 2];
   assign rowColCode = state.sdramCtrl[awst_pkg::ROW_COL_LSB +: 2];

   // address decode and read mux
   always_comb begin
      mapped = 1'b1;
      readValue = 32'h00000000;
      case (paddr)
         awst_pkg::WAIT_CTRL_OFFSET: begin
            readValue = {16'h0000, state.waitCtrl};
         end
         awst_pkg::SDRAM_CTRL_OFFSET: begin
            readValue = {16'h0000, state.sdramCtrl};
         end
         awst_pkg::STATUS_OFFSET: begin
            readValue = {29'h00000000, gapBusy, memBusy, state.waitSync};
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // register state, apb answer and wait pin synchroniser
   always_comb begin
      next_state = state;
      // two flops; only the second one feeds the timers
      next_state.waitMeta = waitPin;
      next_state.waitSync = state.waitMeta;
      next_state.pready = setupPhase && !state.pready;
      if (setupPhase && !state.pready) begin
         next_state.pslverr = !mapped;
         next_state.prdata = pwrite ? 32'h00000000 : readValue;
      end
      if (accessDone && pwrite && mapped) begin
         // byte lanes 0 and 1 hold the 16-bit registers
         if (paddr == awst_pkg::WAIT_CTRL_OFFSET) begin
            if (pstrb[0]) begin
               next_state.waitCtrl[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
               next_state.waitCtrl[15:8] = pwdata[15:8];
            end
         end
         // no field protection: whole-register rewrites are software's job
         if (paddr == awst_pkg::SDRAM_CTRL_OFFSET) begin
            if (pstrb[0]) begin
               next_state.sdramCtrl[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
               next_state.sdramCtrl[15:8] = pwdata[15:8];
            end
         end
      end
      // manual reset restores wait control but keeps sdram timing
      if (manualReset) begin
         next_state.waitCtrl = awst_pkg::WAIT_CTRL_RESET;
         next_state.pready = 1'b0;
         next_state.pslverr = 1'b0;
         next_state.prdata = 32'h00000000;
         next_state.sdramCtrl = state.sdramCtrl;
      end
   end

   // power-on reset is the only thing that clears sdram timing
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= '0;
         state.waitCtrl <= awst_pkg::WAIT_CTRL_RESET;
         state.sdramCtrl <= awst_pkg::SDRAM_CTRL_RESET;
      end else begin
         state <= next_state;
      end
   end

   // ordinary memory: one base state plus inserted waits, or burst pitch
   always_comb begin
      memStart = memReq.valid && !standby;
      memLoad = 4'h1;
      memHonour = 1'b1;
      case (memReq.kind)
         awst_pkg::MEM_AREA4: begin
            memLoad = 4'h1 + awst_pkg::wait_states(area4Code);
            memHonour = (area4Code != 3'h0);
         end
         awst_pkg::MEM_AREA0_FIRST: begin
            memLoad = 4'h1 + awst_pkg::wait_states(area0Code);
            memHonour = (area0Code != 3'h0);
         end
         awst_pkg::MEM_AREA0_BURST: begin
            memLoad = awst_pkg::burst_states(area0Code);
            memHonour = 1'b1;
         end
         default: begin
            memLoad = 4'h1;
            memHonour = 1'b1;
         end
      endcase
   end

   // sdram gaps; a zero-cycle gap still costs the one-cycle handshake
   always_comb begin
      gapStart = gapReq.valid && !standby;
      gapLoad = 4'h1;
      case (gapReq.kind)
         awst_pkg::GAP_ROW_TO_COL: begin
            gapLoad = {2'h0, rowColCode} + 4'h1;
         end
         awst_pkg::GAP_PRE_NORMAL: begin
            gapLoad = {2'h0, prechargeCode} + 4'h1;
         end
         awst_pkg::GAP_PRE_AFTER_PRECHARGE: begin
            gapLoad = {2'h0, prechargeCode};
         end
         awst_pkg::GAP_PRE_AFTER_SELF_REFRESH: begin
            gapLoad = 4'h2 + 4'(3 * prechargeCode);
         end
         default: begin
            gapLoad = 4'h1;
         end
      endcase
   end

   // memory access timer, stretched by the synchronised wait pin
   awst_cycle_timer #(
      .CNT_W(awst_pkg::CNT_W)
   ) memTimer (
      .clk(clk),
      .srst(srst),
      .clear(manualReset),
      .start(memStart),
      .load(memLoad),
      .honourWait(memHonour),
      .waitIn(state.waitSync),
      .busy(memBusy),
      .done(memDone)
   );

   // sdram gap timer; sdram commands never look at the wait pin
   awst_cycle_timer #(
      .CNT_W(awst_pkg::CNT_W)
   ) gapTimer (
      .clk(clk),
      .srst(srst),
      .clear(manualReset),
      .start(gapStart),
      .load(gapLoad),
      .honourWait(1'b0),
      .waitIn(state.waitSync),
      .busy(gapBusy),
      .done(gapDone)
   );

   assign prdata = state.prdata;
   assign pready = state.pready;
   assign pslverr = state.pslverr;
   assign waitCtrl = state.waitCtrl;
   assign sdramCtrl = state.sdramCtrl;

endmodule : awst_timing_ctrl

// File: tb/awst_ext_mem.sv
// external memory model: holds the wait pin after each access start.
// assumes select is the one-cycle request valid seen by the block.
module awst_ext_mem (
   input wire logic clk, // bus clock
   input wire logic select, // access start
   input wire logic [3:0] holdCycles, // wait length, 0 is prompt
   output logic waitPin // high stretches the access
);
   logic [3:0] left = 4'h0;
   // a slow device reloads its wait length on every start
   always_ff @(posedge clk) begin
      if (select)
         left <= holdCycles;
      else if (left != 4'h0)
         left <= left - 4'h1;
   end
   // wait rises with the select itself, so even the earliest decision sees it
   assign waitPin = (left != 4'h0) || (select && holdCycles != 4'h0);
endmodule : awst_ext_mem

// File: tb/awst_timing_ctrl_chk.sv
// checker for awst_timing_ctrl: apb answer, sdram register, timers.
// assumes one clock domain; bound to awst_timing_ctrl by the bind below.
module awst_timing_ctrl_chk (
   input wire logic clk, // clock
   input wire logic srst, // power-on reset
   input wire logic manualReset, // manual reset
   input wire logic standby, // standby
   input wire logic psel, // select
   input wire logic penable, // enable
   input wire logic pwrite, // direction
   input wire logic [7:0] paddr, // address
   input wire logic [31:0] pwdata, // write data
   input wire logic pready, // ready
   input wire logic pslverr, // error
   input wire awst_pkg::awst_mem_req_type memReq, // access start
   input wire logic memBusy, // access busy
   input wire logic memDone, // access done
   input wire awst_pkg::awst_gap_req_type gapReq, // gap start
   input wire logic gapBusy, // gap busy
   input wire logic gapDone, // gap done
   input wire logic [15:0] waitCtrl, // wait fields
   input wire logic [15:0] sdramCtrl // sdram fields
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   localparam logic [3:0] WS [8] = '{4'h0, 4'h1, 4'h2, 4'h3,
      4'h4, 4'h6, 4'h8, 4'hA};
   localparam logic [3:0] BS [8] = '{4'h2, 4'h2, 4'h3, 4'h4,
      4'h4, 4'h6, 4'h8, 4'hA};
   logic mTake, gTake, mBurst, mHon;
   logic [2:0] mCode;
   logic [1:0] gCode;
   logic [4:0] mCnt, gCnt, mExp, gExp;
   logic [15:0] wLow;
   // a start counts only when idle, awake and out of manual reset
   assign mTake = memReq.valid && !memBusy && !standby && !manualReset;
   assign gTake = gapReq.valid && !gapBusy && !standby && !manualReset;
   assign mBurst = memReq.kind == awst_pkg::MEM_AREA0_BURST;
   assign mCode = (memReq.kind == awst_pkg::MEM_AREA4) ?
      waitCtrl[9:7] : waitCtrl[2:0];
   assign gCode = (gapReq.kind == awst_pkg::GAP_ROW_TO_COL) ?
      sdramCtrl[13:12] : sdramCtrl[15:14];
   assign wLow = pwdata[15:0];
   // busy cycles since the taking edge, and the count expected at done
   always_ff @(posedge clk) begin
      if (srst || manualReset) begin
         mCnt <= 5'h00;
         gCnt <= 5'h00;
      end else begin
         if (mTake) begin
            mCnt <= 5'h00;
            mExp <= mBurst ? {1'b0, BS[mCode]} : {1'b0, WS[mCode]} + 5'h01;
            mHon <= mBurst || (mCode != 3'h0);
         end else if (memBusy)
            mCnt <= mCnt + 5'h01;
         if (gTake) begin
            gCnt <= 5'h00;
            case (gapReq.kind)
               awst_pkg::GAP_PRE_AFTER_PRECHARGE:
                  gExp <= (gCode == 2'h0) ? 5'h01 : {3'h0, gCode};
               awst_pkg::GAP_PRE_AFTER_SELF_REFRESH:
                  gExp <= 5'h02 + 5'h03 * {3'h0, gCode};
               default: gExp <= {3'h0, gCode} + 5'h01;
            endcase
         end else if (gapBusy)
            gCnt <= gCnt + 5'h01;
      end
   end
   a_ready_next: assert property (
      psel && !penable && !manualReset |=> pready)
      else $error("no ready after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_reg_write: assert property (
      psel && penable && pwrite && pready && paddr == 8'h04
      |=> sdramCtrl == $past(wLow)) else $error("sdram write lost");
   a_por_clear: assert property (
      @(posedge clk) disable iff (1'b0) srst |=> sdramCtrl == 16'h0000)
      else $error("sdram not cleared");
   a_keep_sdram: assert property (
      (manualReset || standby) && !psel |=> $stable(sdramCtrl))
      else $error("sdram changed in reset or standby");
   a_mem_early: assert property (memDone |-> mCnt >= mExp)
      else $error("access ended early");
   a_mem_exact: assert property (
      memDone && !mHon |-> mCnt == mExp) else $error("access count");
   a_gap_exact: assert property (
      gapDone |-> gCnt == gExp) else $error("gap count");
   a_unmapped_addr: assert property (
      psel && !penable && !manualReset && paddr > 8'h08 |=> pslverr)
      else $error("unmapped not refused");
   c_burst: cover property (mTake && mBurst);
   c_self: cover property (gapDone && gCnt == 5'h0B);
   c_err: cover property (pready && pslverr);
endmodule : awst_timing_ctrl_chk
bind awst_timing_ctrl awst_timing_ctrl_chk u_chk (.clk, .srst,
   .manualReset, .standby, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pready, .pslverr, .memReq, .memBusy, .memDone, .gapReq, .gapBusy,
   .gapDone, .waitCtrl, .sdramCtrl);

// File: tb/awst_timing_ctrl_tb_top.sv
// bench for awst_timing_ctrl: apb register tests and timer counts.
// assumes the external memory model and the bound checker.
module awst_timing_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic manualReset = 1'b0;
   logic standby = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, n;
   logic [3:0] pstrb = 4'hF, holdCycles = 4'h0;
   logic pready, pslverr, waitPin, memBusy, memDone, gapBusy, gapDone, er;
   logic [15:0] waitCtrl, sdramCtrl;
   awst_pkg::awst_mem_req_type memReq = '0;
   awst_pkg::awst_gap_req_type gapReq = '0;
   int n_fail = 0;
   int comparisons = 0;
   logic [4:0] FC [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07,
      5'h09, 5'h0B};
   logic [4:0] BC [8] = '{5'h02, 5'h02, 5'h03, 5'h04, 5'h04, 5'h06,
      5'h08, 5'h0A};
   logic [4:0] GP [16] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h01, 5'h02,
      5'h03, 5'h04, 5'h01, 5'h01, 5'h02, 5'h03, 5'h02, 5'h05, 5'h08, 5'h0B};
   awst_timing_ctrl DUT (.clk, .srst, .manualReset, .standby, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .memReq, .waitPin, .memBusy, .memDone, .gapReq, .gapBusy,
      .gapDone, .waitCtrl, .sdramCtrl);
   awst_ext_mem u_mem (.clk, .select(memReq.valid), .holdCycles, .waitPin);
   // 250 MHz bus clock
   always #2 clk = ~clk;
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask : chk
   // one apb transfer; request held until ready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // one-cycle start, then count cycles up to done
   task automatic run(input bit g, input logic [1:0] k);
      @(posedge clk);
      if (g)
         gapReq <= '{1'b1, awst_pkg::awst_gap_kind_type'(k)};
      else
         memReq <= '{1'b1, awst_pkg::awst_mem_kind_type'(k)};
      @(posedge clk);
      memReq.valid <= 1'b0;
      gapReq.valid <= 1'b0;
      n = 32'h0;
      do begin
         @(posedge clk);
         n++;
      end while ((g ? gapDone : memDone) !== 1'b1 && n < 32'h28);
      // done is seen at the edge that closes its cycle, one past the count
      n = n - 32'h1;
   endtask : run
   task automatic finish_test;
      if (n_fail == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #40000;
      n_fail++;
      finish_test;
   end
   // register, reset and timer sequence
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 8'h04, 32'hFFFF5A5A);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h00005A5A);
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, er}, 32'h1);
      manualReset <= 1'b1;
      standby <= 1'b1;
      repeat (2) @(posedge clk);
      manualReset <= 1'b0;
      standby <= 1'b0;
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h00005A5A);
      chk({16'h0, sdramCtrl}, 32'h00005A5A);
      chk({16'h0, waitCtrl}, {16'h0, awst_pkg::WAIT_CTRL_RESET});
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, 8'h00, {22'h0, c[2:0], 4'h0, c[2:0]});
         run(1'b0, 2'h0);
         chk(n, 32'(FC[c]));
         run(1'b0, 2'h1);
         chk(n, 32'(FC[c]));
         run(1'b0, 2'h2);
         chk(n, 32'(BC[c]));
      end
      // slow memory: wait stretches honoured codes, not first cycles at code 000
      holdCycles <= 4'hA;
      run(1'b0, 2'h2);
      chk({31'h0, n > 32'h0A}, 32'h1);
      run(1'b0, 2'h0);
      chk({31'h0, n > 32'h0B}, 32'h1);
      apb(1'b1, 8'h00, 32'h0);
      run(1'b0, 2'h0);
      chk(n, 32'h1);
      run(1'b0, 2'h1);
      chk(n, 32'h1);
      holdCycles <= 4'h0;
      for (int c = 0; c < 4; c++) begin
         // timing fields are set once per power-on, so reset before each
         srst <= 1'b1;
         repeat (2) @(posedge clk);
         srst <= 1'b0;
         apb(1'b1, 8'h04, {16'h0, c[1:0], c[1:0], 12'h000});
         for (int k = 0; k < 4; k++) begin
            run(1'b1, k[1:0]);
            chk(n, 32'(GP[k * 4 + c]));
         end
      end
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h0);
      finish_test;
   end
endmodule : awst_timing_ctrl_tb_top
